/* inc/rx_status_map.svh */
// register map, field positions, reset values and sizes of the receive status block
//
// Summary of operation
// - with address detect on in 9-bit mode, accept only frames whose ninth bit is one
// - with address detect off, accept every frame; ninth bit left for software parity
// - in 8-bit mode the address detect enable has no effect on reception
// - framing error flag follows the frame shown; it changes after data read and next byte
// - overrun flag sets on overrun and clears when continuous receive is cleared
// - ninth bit of each frame is captured into a readable status bit
// - continuous receive keeps receiving until cleared or halted by an overrun, and overrides single receive
`ifndef RX_STATUS_MAP_SVH
`define RX_STATUS_MAP_SVH

// ****************************************
// register byte offsets
// ****************************************
`define RXS_STATUS_OFS 32'h0000_0000
`define RXS_DATA_OFS 32'h0000_0004

// ****************************************
// receive status/control field positions
// ****************************************
`define RXS_NINE_BIT 6
`define RXS_SINGLE_BIT 5
`define RXS_CONT_BIT 4
`define RXS_ADDR_BIT 3
`define RXS_FRAMING_ERROR_FLAG_BIT 2
`define RXS_OVERRUN_ERROR_FLAG_BIT 1
`define RXS_NINTH_RECEIVED_BIT_BIT 0

// ****************************************
// reset values and sizes
// ****************************************
`define RXS_CTRL_RESET 8'h00
`define RXS_DATA_RESET 8'h00
`define RXS_FIFO_DEPTH 4
`define RXS_FIFO_WIDTH 10

`endif

/* inc/rx_status_pkg.sv */
// types shared by the receive status block
package rx_status_pkg;

    // ****************************************
    // bus slave states
    // ****************************************
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACCESS = 2'b10
    } bus_state_t;

endpackage

/* logic/rx_fifo.sv */
// small first-in first-out buffer held in flip-flops
`timescale 1ns/1ns
`default_nettype none
module rx_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [CW-1:0] count;

    function automatic logic [AW-1:0] ptr_step(input logic [AW-1:0] ptr);
        ptr_step = (ptr == AW'(DEPTH - 1)) ? '0 : ptr + AW'(1);
    endfunction

    wire logic push = in_valid & in_ready;
    wire logic pop = out_valid & out_ready;
    assign in_ready = (count != CW'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];

    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= ptr_step(wr_ptr);
            end
            if (pop) begin
                rd_ptr <= ptr_step(rd_ptr);
            end
            if (push && !pop) begin
                count <= count + CW'(1);
            end else if (pop && !push) begin
                count <= count - CW'(1);
            end
        end
    end

    fifo_bound_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (count <= CW'(DEPTH)) && ((count == CW'(DEPTH)) == !in_ready))
        else $error("fifo occupancy out of range");
    fifo_push_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (push && !pop) |=> (count == $past(count) + CW'(1)))
        else $error("fifo push not counted");
endmodule
`default_nettype wire

/* logic/rx_addr_filter.sv */
// decides whether a received frame is kept, by address detection
`timescale 1ns/1ns
`default_nettype none
module rx_addr_filter (
    // clock and reset, for checks only
    input wire logic mclk,
    input wire logic rst_n,
    // mode
    input wire logic nine_bit_receive_enable,
    input wire logic address_detect_enable,
    // frame
    input wire logic ninth_bit,
    output logic accept
);
    wire logic detect_active = nine_bit_receive_enable & address_detect_enable;
    assign accept = !detect_active | ninth_bit;

    addr_only_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (nine_bit_receive_enable && address_detect_enable) |-> (accept == ninth_bit))
        else $error("address frame filter wrong");
    eight_bit_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !nine_bit_receive_enable |-> accept)
        else $error("8-bit frame dropped");
endmodule
`default_nettype wire

/* logic/rx_status_top.sv */
// receive status and address detect block with its register slave
`timescale 1ns/1ns
`default_nettype none
`include "rx_status_map.svh"
module rx_status_top #(
    parameter int FIFO_WIDTH = `RXS_FIFO_WIDTH,
    parameter int FIFO_DEPTH = `RXS_FIFO_DEPTH
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // register bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // frames from the bit sampler
    input wire logic frame_valid,
    input wire logic [8:0] frame_data,
    input wire logic frame_error,
    // status toward the rest of the unit
    output logic receive_interrupt_flag,
    output logic nine_bit_receive_enable,
    output logic continuous_receive_enable
);
    // ****************************************
    // control and status state
    // ****************************************
    logic single_receive_enable;
    logic address_detect_enable;
    logic framing_error_flag;
    logic overrun_error_flag;
    logic ninth_received_bit;
    logic [7:0] receive_data_register;
    localparam logic [7:0] CTRL_RESET = `RXS_CTRL_RESET;

    // ****************************************
    // bus slave state
    // ****************************************
    rx_status_pkg::bus_state_t state;
    rx_status_pkg::bus_state_t next_state;
    logic [31:0] addr_q;
    logic write_q;

    wire logic bus_take = hsel & htrans[1] & hready & (state == rx_status_pkg::BUS_IDLE);
    wire logic in_access = (state == rx_status_pkg::BUS_ACCESS);
    wire logic hit_status = (addr_q == `RXS_STATUS_OFS);
    wire logic hit_data = (addr_q == `RXS_DATA_OFS);
    wire logic wr_status = in_access & write_q & hit_status;
    wire logic rd_data = in_access & !write_q & hit_data;
    wire logic unused_size = ^hsize;

    always_comb begin
        case (state)
            rx_status_pkg::BUS_IDLE: begin
                next_state = bus_take ? rx_status_pkg::BUS_ACCESS : rx_status_pkg::BUS_IDLE;
            end
            rx_status_pkg::BUS_ACCESS: begin
                next_state = rx_status_pkg::BUS_IDLE;
            end
            default: begin
                next_state = rx_status_pkg::BUS_IDLE;
            end
        endcase
    end

    // ****************************************
    // read value selection
    // ****************************************
    wire logic [7:0] status_value = {
        1'b0,
        nine_bit_receive_enable,
        single_receive_enable,
        continuous_receive_enable,
        address_detect_enable,
        framing_error_flag,
        overrun_error_flag,
        ninth_received_bit
    };
    wire logic [31:0] read_value = hit_status ? {24'h00_0000, status_value} :
        hit_data ? {24'h00_0000, receive_data_register} : 32'h0000_0000;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state <= rx_status_pkg::BUS_IDLE;
            addr_q <= 32'h0000_0000;
            write_q <= 1'b0;
            hreadyout <= 1'b1;
            hrdata <= 32'h0000_0000;
            hresp <= 1'b0;
        end else begin
            state <= next_state;
            hresp <= 1'b0;
            if (bus_take) begin
                addr_q <= haddr;
                write_q <= hwrite;
            end
            hreadyout <= !bus_take;
            if (in_access) begin
                hrdata <= write_q ? 32'h0000_0000 : read_value;
            end
        end
    end

    // ****************************************
    // frame intake
    // ****************************************
    logic frame_accept;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [FIFO_WIDTH-1:0] fifo_out_data;

    // continuous or single receive keeps the receiver open; overrun halts it
    wire logic rx_active = (continuous_receive_enable | single_receive_enable) & !overrun_error_flag;
    wire logic frame_seen = frame_valid & rx_active;
    wire logic frame_take = frame_seen & frame_accept;
    wire logic fifo_in_valid = frame_take & fifo_in_ready;
    wire logic overrun_event = frame_take & !fifo_in_ready;
    wire logic [FIFO_WIDTH-1:0] fifo_in_data = FIFO_WIDTH'({frame_error, frame_data});
    wire logic hold_load = fifo_out_valid & !receive_interrupt_flag;
    wire logic clear_overrun = wr_status & !hwdata[`RXS_CONT_BIT];
    wire logic single_done = frame_take & !continuous_receive_enable;

    rx_addr_filter u_filter (
        .mclk(mclk),
        .rst_n(rst_n),
        .nine_bit_receive_enable(nine_bit_receive_enable),
        .address_detect_enable(address_detect_enable),
        .ninth_bit(frame_data[8]),
        .accept(frame_accept)
    );

    rx_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .mclk(mclk),
        .rst_n(rst_n),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in_data),
        .out_valid(fifo_out_valid),
        .out_ready(!receive_interrupt_flag),
        .out_data(fifo_out_data)
    );

    // ****************************************
    // control register
    // ****************************************
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            nine_bit_receive_enable <= CTRL_RESET[`RXS_NINE_BIT];
            continuous_receive_enable <= CTRL_RESET[`RXS_CONT_BIT];
            address_detect_enable <= CTRL_RESET[`RXS_ADDR_BIT];
        end else if (wr_status) begin
            nine_bit_receive_enable <= hwdata[`RXS_NINE_BIT];
            continuous_receive_enable <= hwdata[`RXS_CONT_BIT];
            address_detect_enable <= hwdata[`RXS_ADDR_BIT];
        end
    end

    // single receive ends after one kept frame unless continuous receive is on
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            single_receive_enable <= CTRL_RESET[`RXS_SINGLE_BIT];
        end else if (wr_status) begin
            single_receive_enable <= hwdata[`RXS_SINGLE_BIT];
        end else if (single_done) begin
            single_receive_enable <= 1'b0;
        end
    end

    // overrun: a new overrun wins over a clear in the same cycle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            overrun_error_flag <= 1'b0;
        end else begin
            overrun_error_flag <= overrun_event | (overrun_error_flag & !clear_overrun);
        end
    end

    // ****************************************
    // holding register shown to software
    // ****************************************
    // error and ninth bit belong to the byte held, so they change only when it is replaced
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            receive_interrupt_flag <= 1'b0;
            receive_data_register <= `RXS_DATA_RESET;
            framing_error_flag <= 1'b0;
            ninth_received_bit <= 1'b0;
        end else if (hold_load) begin
            receive_interrupt_flag <= 1'b1;
            receive_data_register <= fifo_out_data[7:0];
            framing_error_flag <= fifo_out_data[9];
            ninth_received_bit <= fifo_out_data[8];
        end else if (rd_data) begin
            receive_interrupt_flag <= 1'b0;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    addr_drop_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (frame_valid && nine_bit_receive_enable && address_detect_enable && !frame_data[8])
        |-> !fifo_in_valid && !overrun_event)
        else $error("address-less frame kept");
    accept_all_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (frame_valid && rx_active && !address_detect_enable) |-> (fifo_in_valid || overrun_event))
        else $error("frame lost with detect off");
    framing_error_flag_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
        $changed(framing_error_flag) |-> $past(hold_load))
        else $error("framing flag moved without new byte");
    framing_error_flag_value_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (frame_take && fifo_in_ready && !fifo_out_valid && !receive_interrupt_flag)
        |=> ##1 (framing_error_flag == $past(frame_error, 2)))
        else $error("framing flag not taken from frame");
    overrun_error_flag_set_a: assert property (@(posedge mclk) disable iff (!rst_n)
        overrun_event |=> overrun_error_flag && !fifo_in_valid)
        else $error("overrun not flagged");
    overrun_error_flag_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (clear_overrun && !overrun_event) |=> !overrun_error_flag && !continuous_receive_enable)
        else $error("overrun not cleared");
    ninth_cap_a: assert property (@(posedge mclk) disable iff (!rst_n)
        hold_load |=> (ninth_received_bit == $past(fifo_out_data[8])) && receive_interrupt_flag)
        else $error("ninth bit not captured");
    cont_keeps_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (frame_take && continuous_receive_enable && !wr_status)
        |=> continuous_receive_enable && (single_receive_enable == $past(single_receive_enable)))
        else $error("continuous receive stopped");
    single_once_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (single_done && !wr_status) |=> !single_receive_enable)
        else $error("single receive not ended");
    bus_wait_a: assert property (@(posedge mclk) disable iff (!rst_n)
        bus_take |=> !hreadyout ##1 (hreadyout && !hresp))
        else $error("bus answer timing wrong");
    // receiver closed: nothing may enter the buffer or count as overrun
    rx_closed_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (frame_valid && !continuous_receive_enable && !single_receive_enable)
        |-> !fifo_in_valid && !overrun_event)
        else $error("frame taken while receive off");
    overrun_error_flag_block_a: assert property (@(posedge mclk) disable iff (!rst_n)
        overrun_error_flag |-> !fifo_in_valid)
        else $error("frame taken during overrun");
    ninth_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
        $changed(ninth_received_bit) |-> $past(hold_load))
        else $error("ninth bit moved without new byte");
    data_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (rd_data && receive_interrupt_flag) |=> !receive_interrupt_flag)
        else $error("data read did not free holding register");
endmodule
`default_nettype wire

/* tb/frame_source.sv */
// remote sender model that presents received frames to the block
`timescale 1ns/1ns
`default_nettype none
module frame_source (
    // clock
    input wire logic mclk,
    // frame toward the block
    output logic frame_valid,
    output logic [8:0] frame_data,
    output logic frame_error
);
    initial begin
        frame_valid = 1'h0;
        frame_data = 9'h000;
        frame_error = 1'h0;
    end

    // ****************************************
    // one frame for one cycle
    // ****************************************
    // after the frame the lines show the inverse of the last value, not a held copy
    task automatic send(input logic [8:0] d, input logic e);
        @(posedge mclk);
        frame_valid <= 1'h1;
        frame_data <= d;
        frame_error <= e;
        @(posedge mclk);
        frame_valid <= 1'h0;
        frame_data <= ~d;
        frame_error <= ~e;
    endtask
endmodule
`default_nettype wire

/* tb/tb.sv */
// self-checking bench for the receive status block
`timescale 1ns/1ns
`default_nettype none
`include "rx_status_map.svh"
module tb;
    localparam logic [31:0] ST = `RXS_STATUS_OFS;
    localparam logic [31:0] DT = `RXS_DATA_OFS;
    logic mclk, rst_n, hsel, hwrite, rd_ph;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata;
    logic hreadyout, hresp, rif, nine_en, cont_en, fv, fe;
    logic [8:0] fd;
    logic [31:0] exp_q[$];
    int n_fail, total_checks, cyc;

    rx_status_top dut_u (
        .mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .frame_valid(fv), .frame_data(fd), .frame_error(fe),
        .receive_interrupt_flag(rif), .nine_bit_receive_enable(nine_en),
        .continuous_receive_enable(cont_en)
    );
    frame_source src_u (.mclk(mclk), .frame_valid(fv), .frame_data(fd), .frame_error(fe));

    // ****************************************
    // helpers
    // ****************************************
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] e, input logic [31:0] s);
        total_checks++;
        if (s !== e) begin
            n_fail++;
            $display("BAD hrdata expected %h seen %h", e, s);
        end
    endtask

    task automatic chk_bit(input string nm, input logic e, input logic s);
        total_checks++;
        if (s !== e) begin
            n_fail++;
            $display("BAD %s expected %b seen %b", nm, e, s);
        end
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic done(input string s);
        $display("test %s done", s);
    endtask

    // single word transfer; request held until hready is sampled high
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge mclk);
        hsel <= 1'h1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        @(posedge mclk);
        while (hreadyout !== 1'h1) @(posedge mclk);
        htrans <= 2'h0;
        hwdata <= d;
        rd_ph <= ~wr;
        @(posedge mclk);
        while (hreadyout !== 1'h1) @(posedge mclk);
        rd_ph <= 1'h0;
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'h0, a, 32'h0000_0000);
    endtask

    // read data is taken at the edge that ends the data phase
    always @(posedge mclk) begin
        if (rd_ph === 1'h1 && hreadyout === 1'h1) begin
            chk_word(exp_q.pop_front(), hrdata);
        end
    end

    initial begin
        mclk = 1'h0;
        forever #25 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            end_of_test();
        end
    end

    // ****************************************
    // tests
    // ****************************************
    initial begin
        logic [7:0] b;
        logic p;
        rst_n = 1'h0;
        hsel = 1'h0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'h0;
        hwdata = 32'h0;
        rd_ph = 1'h0;
        b = 8'($urandom(43));
        repeat (20) @(posedge mclk);
        rst_n <= 1'h1;
        chk_bit("hreadyout", 1'h1, hreadyout);
        chk_bit("rif", 1'h0, rif);
        rd(ST, 32'h0000_0000);
        rd(DT, 32'h0000_0000);
        bus(1'h1, 32'h0000_0008, 32'hFFFF_FFFF);
        bus(1'h1, DT, 32'hFFFF_FFFF);
        rd(32'h0000_0008, 32'h0000_0000);
        rd(DT, 32'h0000_0000);
        chk_bit("hresp", 1'h0, hresp);
        done("reset");
        bus(1'h1, ST, 32'h0000_0018);
        src_u.send(9'h0A5, 1'h0);
        wait_cyc(4);
        chk_bit("rif", 1'h1, rif);
        rd(ST, 32'h0000_0018);
        rd(DT, 32'h0000_00A5);
        #1 chk_bit("rif", 1'h0, rif);
        done("eight_bit");
        bus(1'h1, ST, 32'h0000_0058);
        chk_bit("nine_en", 1'h1, nine_en);
        chk_bit("cont_en", 1'h1, cont_en);
        src_u.send(9'h012, 1'h0);
        wait_cyc(4);
        chk_bit("rif", 1'h0, rif);
        src_u.send(9'h134, 1'h0);
        wait_cyc(4);
        rd(ST, 32'h0000_0059);
        rd(DT, 32'h0000_0034);
        done("address_detect");
        bus(1'h1, ST, 32'h0000_0050);
        repeat (4) begin
            b = 8'($urandom);
            p = ^b;
            src_u.send({p, b}, 1'h0);
            wait_cyc(4);
            rd(ST, {24'h0, 8'h50 | {7'h0, p}});
            rd(DT, {24'h0, b});
        end
        done("parity_bit");
        src_u.send(9'h03C, 1'h1);
        src_u.send(9'h0C3, 1'h0);
        wait_cyc(4);
        rd(ST, 32'h0000_0054);
        rd(DT, 32'h0000_003C);
        wait_cyc(4);
        rd(ST, 32'h0000_0050);
        rd(DT, 32'h0000_00C3);
        done("framing");
        bus(1'h1, ST, 32'h0000_0060);
        src_u.send(9'h111, 1'h0);
        src_u.send(9'h122, 1'h0);
        wait_cyc(4);
        rd(ST, 32'h0000_0041);
        rd(DT, 32'h0000_0011);
        #1 chk_bit("rif", 1'h0, rif);
        bus(1'h1, ST, 32'h0000_0070);
        src_u.send(9'h133, 1'h0);
        src_u.send(9'h144, 1'h0);
        wait_cyc(4);
        rd(DT, 32'h0000_0033);
        wait_cyc(3);
        rd(DT, 32'h0000_0044);
        rd(ST, 32'h0000_0071);
        done("single_receive");
        bus(1'h1, ST, 32'h0000_0050);
        for (int i = 1; i <= 7; i++) src_u.send({1'h0, 8'(i)}, 1'h0);
        wait_cyc(4);
        rd(ST, 32'h0000_0052);
        for (int i = 1; i <= 5; i++) begin
            rd(DT, 32'(i));
            wait_cyc(3);
        end
        chk_bit("rif", 1'h0, rif);
        bus(1'h1, ST, 32'h0000_0040);
        rd(ST, 32'h0000_0040);
        chk_bit("cont_en", 1'h0, cont_en);
        done("overrun");
        bus(1'h1, ST, 32'h0000_0058);
        src_u.send(9'h155, 1'h1);
        wait_cyc(4);
        chk_bit("rif", 1'h1, rif);
        rst_n <= 1'h0;
        wait_cyc(3);
        chk_bit("rif", 1'h0, rif);
        chk_bit("nine_en", 1'h0, nine_en);
        chk_bit("cont_en", 1'h0, cont_en);
        chk_bit("hreadyout", 1'h1, hreadyout);
        rst_n <= 1'h1;
        rd(ST, 32'h0000_0000);
        rd(DT, 32'h0000_0000);
        done("mid_reset");
        end_of_test();
    end
endmodule
`default_nettype wire
